// ### hw/ppr_pkg.sv
// shared constants and types for the power, reset and thermal sideband link
// Contract
// - drive thermal alert when sensor reaches limit
// - external thermal alert engages circuit when bidirectional
// - thermal pin output only until firmware enables
// - status indicator asserted in normal and deep sleep
// - platform raises supply stable cleanly when ready
// - supply stable may drop; re-rise only when stable
// - supply stable kept high during boundary scan
// - only bus owner drives request, strobe qualified
// - reset invalidates cache, writes back nothing
// - power-on reset held two milliseconds minimum
// - agents release bus outputs within two clocks
// - straps valid for setup before reset release
// - only response agent drives response status
// - sleep request in stop-grant enters sleep
// - sleep ignores snoops and interrupts
// - sleep release returns to stop-grant
// - deep sleep request in sleep enters deep sleep
// - clock stop enters stop-grant, issues acknowledge
`default_nettype none
package ppr_pkg;
    // host clock and platform timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_HOLD_NS = 2_000_000;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETUP_NS = 1_000;
    localparam int STRAP_SETUP_CYC =
        (STRAP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // link clock half period in host clock cycles
    localparam int LINK_HALF_CYC = 3;
    // widths
    localparam int REQ_W = 5;
    localparam int RS_W = 3;
    localparam int STRAP_W = 4;
    localparam int OE_HIST_W = 3;
    // bus encodings, active low
    localparam logic [REQ_W-1:0] REQ_IDLE_N = 5'h1f;
    localparam logic [REQ_W-1:0] REQ_STOP_GRANT_ACK_N = 5'h17;
    localparam logic [RS_W-1:0] RS_IDLE_N = 3'h7;
    localparam logic [RS_W-1:0] RS_DONE_N = 3'h4;
    // device sideband synchroniser layout
    localparam int SB_W = 5;
    localparam int SB_SUPPLY = 4;
    localparam int SB_STOP = 3;
    localparam int SB_SLEEP = 2;
    localparam int SB_DEEP = 1;
    localparam int SB_THERM = 0;
    localparam logic [SB_W-1:0] SB_INIT = 5'h0f;
    // host input synchroniser layout
    localparam int HS_W = 8;
    localparam int HS_THERM = 7;
    localparam int HS_PSI = 6;
    localparam int HS_STB = 5;
    localparam logic [HS_W-1:0] HS_INIT = 8'hff;
    typedef enum logic [1:0] {
        PWR_NORMAL, PWR_STOP_GRANT, PWR_SLEEP, PWR_DEEP_SLEEP
    } ppr_pwr_e;
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_CMD, BUS_STROBE, BUS_DONE
    } ppr_bus_e;
    typedef enum logic [1:0] {
        PLT_OFF, PLT_HOLD, PLT_RUN
    } ppr_plt_e;
endpackage
`default_nettype wire

// ### hw/ppr_link_if.sv
// link between the platform end and the device end
`timescale 1ns/1ps
`default_nettype none
interface ppr_link_if;
    import ppr_pkg::*;
    logic link_clk;
    logic reset_n;
    logic supply_stable;
    logic clock_stop_req_n;
    logic sleep_req_n;
    logic deep_sleep_req_n;
    logic [STRAP_W-1:0] strap;
    logic dev_thermal_o;
    logic dev_thermal_oe;
    logic host_thermal_o;
    logic host_thermal_oe;
    logic thermal_alert_n;
    logic power_status_ind_n;
    logic [REQ_W-1:0] req_o;
    logic req_oe;
    logic [REQ_W-1:0] req_n;
    logic stb_o;
    logic stb_oe;
    logic addr_strobe0_n;
    logic [RS_W-1:0] rs_o;
    logic rs_oe;
    logic [RS_W-1:0] response_status_n;
    // open drain with pull-up; undriven bus lines rest high
    assign thermal_alert_n = ~((dev_thermal_oe & ~dev_thermal_o) |
                               (host_thermal_oe & ~host_thermal_o));
    assign req_n = req_oe ? req_o : REQ_IDLE_N;
    assign addr_strobe0_n = stb_oe ? stb_o : 1'b1;
    assign response_status_n = rs_oe ? rs_o : RS_IDLE_N;
    modport dev (
        input link_clk, reset_n, supply_stable, clock_stop_req_n,
        input sleep_req_n, deep_sleep_req_n, strap, thermal_alert_n,
        input response_status_n,
        output dev_thermal_o, dev_thermal_oe, power_status_ind_n,
        output req_o, req_oe, stb_o, stb_oe
    );
    modport host (
        output link_clk, reset_n, supply_stable, clock_stop_req_n,
        output sleep_req_n, deep_sleep_req_n, strap,
        output host_thermal_o, host_thermal_oe, rs_o, rs_oe,
        input thermal_alert_n, power_status_ind_n, req_n, addr_strobe0_n
    );
endinterface
`default_nettype wire

// ### hw/ppr_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ppr_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clocking
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] agree;

    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            sync_out <= INIT;
        end else if (ce_in) begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sync_out <= (agree & s3_r) | (~agree & sync_out);
        end
    end
endmodule
`default_nettype wire

// ### hw/ppr_host_end.sv
// platform end: link clock, supply and reset sequencing, sideband, responses
`timescale 1ns/1ps
`default_nettype none
module ppr_host_end #(
    parameter int RESET_HOLD = ppr_pkg::RESET_HOLD_CYC,
    parameter int STRAP_SETUP = ppr_pkg::STRAP_SETUP_CYC,
    parameter int LINK_HALF = ppr_pkg::LINK_HALF_CYC
) (
    // clocking
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // link to the device
    ppr_link_if.host link,
    // platform controls
    input wire logic supply_ok_in,
    input wire logic reset_req_in,
    input wire logic [ppr_pkg::STRAP_W-1:0] strap_in,
    input wire logic clock_stop_in,
    input wire logic sleep_in,
    input wire logic deep_sleep_in,
    input wire logic thermal_assert_in,
    // observations
    output logic thermal_seen_out,
    output logic power_status_out,
    output logic req_valid_out,
    output logic [ppr_pkg::REQ_W-1:0] req_cmd_out,
    output logic cpu_running_out
);
    import ppr_pkg::*;

    localparam int HOLD_LAST =
        (RESET_HOLD > STRAP_SETUP ? RESET_HOLD : STRAP_SETUP) - 1;
    localparam int HOLD_W = $clog2(HOLD_LAST + 2);
    localparam int DIV_W = $clog2(LINK_HALF + 1);

    logic [DIV_W-1:0] div_r;
    logic link_clk_r;
    logic div_tick;
    logic link_fall;
    ppr_plt_e plt_r;
    logic [HOLD_W-1:0] hold_cnt_r;
    logic hold_done;
    logic reset_n_r;
    logic [HS_W-1:0] hs;
    logic busy_r;

    assign div_tick = (div_r == DIV_W'(LINK_HALF - 1));
    assign link_fall = div_tick && link_clk_r;
    assign hold_done = (hold_cnt_r == HOLD_W'(HOLD_LAST));
    assign link.link_clk = link_clk_r;
    assign link.reset_n = reset_n_r;
    assign cpu_running_out = reset_n_r;

    ppr_sync3 #(.WIDTH(HS_W), .INIT(HS_INIT)) u_in_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .async_in({link.thermal_alert_n, link.power_status_ind_n,
                   link.addr_strobe0_n, link.req_n}),
        .sync_out(hs)
    );

    // link clock divider
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            div_r <= '0;
            link_clk_r <= 1'b0;
        end else if (ce_in) begin
            if (div_tick) begin
                div_r <= '0;
                link_clk_r <= ~link_clk_r;
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    // supply and reset sequencing
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            plt_r <= PLT_OFF;
            hold_cnt_r <= '0;
            link.supply_stable <= 1'b0;
            link.strap <= '0;
        end else if (ce_in) begin
            case (plt_r)
                PLT_OFF: begin
                    if (supply_ok_in) begin
                        plt_r <= PLT_HOLD;
                        link.supply_stable <= 1'b1;
                        link.strap <= strap_in;
                        hold_cnt_r <= '0;
                    end
                end
                PLT_HOLD: begin
                    if (!hold_done) begin
                        hold_cnt_r <= hold_cnt_r + 1'b1;
                    end else if (link_fall && !reset_req_in) begin
                        plt_r <= PLT_RUN;
                    end
                end
                PLT_RUN: begin
                    if (reset_req_in) begin
                        plt_r <= PLT_HOLD;
                        link.strap <= strap_in;
                        hold_cnt_r <= '0;
                    end
                end
                default: plt_r <= PLT_OFF;
            endcase
            // supply loss drops the stable indication at once
            if (!supply_ok_in) begin
                plt_r <= PLT_OFF;
                link.supply_stable <= 1'b0;
            end
        end
    end

    // reset changes only as the link clock falls, so the device sees it
    // settled at its rising edge
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            reset_n_r <= 1'b0;
        end else if (ce_in && link_fall) begin
            if (plt_r != PLT_RUN) begin
                reset_n_r <= 1'b0;
            end else begin
                reset_n_r <= 1'b1;
            end
        end
    end

    // sideband requests and thermal drive
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            link.clock_stop_req_n <= 1'b1;
            link.sleep_req_n <= 1'b1;
            link.deep_sleep_req_n <= 1'b1;
            link.host_thermal_o <= 1'b0;
            link.host_thermal_oe <= 1'b0;
            thermal_seen_out <= 1'b0;
            power_status_out <= 1'b0;
        end else if (ce_in) begin
            link.clock_stop_req_n <= ~clock_stop_in;
            link.sleep_req_n <= ~sleep_in;
            link.deep_sleep_req_n <= ~deep_sleep_in;
            link.host_thermal_o <= 1'b0;
            link.host_thermal_oe <= thermal_assert_in;
            thermal_seen_out <= ~hs[HS_THERM];
            power_status_out <= ~hs[HS_PSI];
        end
    end

    // response agent: request lines are only sampled, never driven
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            busy_r <= 1'b0;
            link.rs_o <= RS_IDLE_N;
            link.rs_oe <= 1'b0;
            req_valid_out <= 1'b0;
            req_cmd_out <= '0;
        end else if (ce_in) begin
            req_valid_out <= 1'b0;
            if (!reset_n_r) begin
                busy_r <= 1'b0;
                link.rs_o <= RS_IDLE_N;
                link.rs_oe <= 1'b0;
            end else if (!busy_r && !hs[HS_STB]) begin
                busy_r <= 1'b1;
                req_cmd_out <= ~hs[REQ_W-1:0];
                req_valid_out <= 1'b1;
                link.rs_o <= RS_DONE_N;
                link.rs_oe <= 1'b1;
            end else if (busy_r && hs[HS_STB]) begin
                busy_r <= 1'b0;
                link.rs_o <= RS_IDLE_N;
                link.rs_oe <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/ppr_dev_end.sv
// device end: power states, thermal pin, reset entry and request issue
`timescale 1ns/1ps
`default_nettype none
module ppr_dev_end #(
    parameter int CACHE_LINES = 8
) (
    // link to the platform; the device runs on its clock
    ppr_link_if.dev link,
    // local reset and clock enable, link clock domain
    input wire logic nrst_in,
    input wire logic ce_in,
    // thermal sensor and firmware controls
    input wire logic temp_hot_in,
    input wire logic tcc_enable_in,
    input wire logic bidir_enable_in,
    // unit service requests
    input wire logic snoop_req_in,
    input wire logic int_req_in,
    input wire logic fill_in,
    input wire logic [$clog2(CACHE_LINES)-1:0] fill_idx_in,
    // power status
    output var ppr_pkg::ppr_pwr_e power_state_out,
    output logic core_clk_en_out,
    output logic bus_clk_en_out,
    output logic pll_on_out,
    output logic in_reset_out,
    // thermal status
    output logic tcc_active_out,
    output logic bidir_on_out,
    // unit service answers
    output logic snoop_ack_out,
    output logic int_ack_out,
    output logic sg_ack_done_out,
    // cache and straps
    output logic [CACHE_LINES-1:0] cache_valid_out,
    output logic [ppr_pkg::STRAP_W-1:0] strap_out
);
    import ppr_pkg::*;

    logic clk;
    logic [SB_W-1:0] side_s;
    logic [RS_W-1:0] rs_s;
    logic rst_now;
    logic stop_req;
    logic sleep_req;
    logic deep_req;
    logic pin_low;
    logic ext_hot;
    ppr_pwr_e pwr_r;
    ppr_pwr_e pwr_nxt;
    ppr_bus_e bus_r;
    logic sg_pend_r;
    logic sg_set;
    logic in_rst_r;
    logic bidir_r;
    logic thermal_oe_r;
    logic [OE_HIST_W-1:0] oe_hist_r;

    // units that keep snooping and taking interrupts
    function automatic logic serving(input ppr_pwr_e st);
        return (st == PWR_NORMAL) || (st == PWR_STOP_GRANT);
    endfunction

    assign clk = link.link_clk;

    // sideband pins arrive unsynchronised
    ppr_sync3 #(.WIDTH(SB_W), .INIT(SB_INIT)) u_side_sync (
        .clk_in(clk),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .async_in({link.supply_stable, link.clock_stop_req_n,
                   link.sleep_req_n, link.deep_sleep_req_n,
                   link.thermal_alert_n}),
        .sync_out(side_s)
    );

    ppr_sync3 #(.WIDTH(RS_W), .INIT(RS_IDLE_N)) u_rs_sync (
        .clk_in(clk),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .async_in(link.response_status_n),
        .sync_out(rs_s)
    );

    // reset comes from the platform aligned to this clock
    assign rst_now = !nrst_in || !link.reset_n || !side_s[SB_SUPPLY];
    assign stop_req = !side_s[SB_STOP];
    assign sleep_req = !side_s[SB_SLEEP];
    assign deep_req = !side_s[SB_DEEP];
    assign pin_low = !side_s[SB_THERM];
    // own drive echoes through the synchroniser; ignore the pin while driving
    // and for three cycles after the drive ends; the echo lasts four
    assign ext_hot = pin_low && !thermal_oe_r && !(|oe_hist_r);
    assign sg_set = (pwr_r == PWR_NORMAL) && (pwr_nxt == PWR_STOP_GRANT);

    // power state transitions
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_NORMAL: begin
                if (stop_req) begin
                    pwr_nxt = PWR_STOP_GRANT;
                end
            end
            PWR_STOP_GRANT: begin
                // sleep waits until the acknowledge has gone out
                if (sleep_req && !sg_pend_r && bus_r == BUS_IDLE) begin
                    pwr_nxt = PWR_SLEEP;
                end else if (!stop_req && !sleep_req) begin
                    pwr_nxt = PWR_NORMAL;
                end
            end
            PWR_SLEEP: begin
                if (!sleep_req) begin
                    pwr_nxt = PWR_STOP_GRANT;
                end else if (deep_req) begin
                    pwr_nxt = PWR_DEEP_SLEEP;
                end
            end
            PWR_DEEP_SLEEP: begin
                if (!deep_req) begin
                    pwr_nxt = PWR_SLEEP;
                end
            end
            default: pwr_nxt = PWR_NORMAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            pwr_r <= PWR_NORMAL;
        end else if (ce_in) begin
            if (rst_now) begin
                pwr_r <= PWR_NORMAL;
            end else begin
                pwr_r <= pwr_nxt;
            end
        end
    end

    // clock gating and power status outputs
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            power_state_out <= PWR_NORMAL;
            core_clk_en_out <= 1'b0;
            bus_clk_en_out <= 1'b0;
            pll_on_out <= 1'b0;
            link.power_status_ind_n <= 1'b1;
        end else if (ce_in) begin
            power_state_out <= pwr_r;
            core_clk_en_out <= (pwr_r == PWR_NORMAL);
            bus_clk_en_out <= serving(pwr_r);
            pll_on_out <= 1'b1;
            link.power_status_ind_n <=
                !((pwr_r == PWR_NORMAL) || (pwr_r == PWR_DEEP_SLEEP));
        end
    end

    // snoops and interrupts answered only while bus units run
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            snoop_ack_out <= 1'b0;
            int_ack_out <= 1'b0;
        end else if (ce_in) begin
            snoop_ack_out <= !rst_now && snoop_req_in && serving(pwr_r);
            int_ack_out <= !rst_now && int_req_in && serving(pwr_r);
        end
    end

    // reset entry, strap capture and cache invalidation
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            in_rst_r <= 1'b1;
            strap_out <= '0;
            cache_valid_out <= '0;
        end else if (ce_in) begin
            in_rst_r <= rst_now;
            if (in_rst_r && !rst_now) begin
                strap_out <= link.strap;
            end
            if (rst_now) begin
                cache_valid_out <= '0;
            end else if (fill_in && serving(pwr_r)) begin
                cache_valid_out[fill_idx_in] <= 1'b1;
            end
        end
    end

    assign in_reset_out = in_rst_r;

    // thermal pin and control circuit
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            bidir_r <= 1'b0;
            thermal_oe_r <= 1'b0;
            oe_hist_r <= '0;
            tcc_active_out <= 1'b0;
            link.dev_thermal_o <= 1'b0;
            link.dev_thermal_oe <= 1'b0;
        end else if (ce_in) begin
            if (rst_now) begin
                bidir_r <= 1'b0;
            end else if (bidir_enable_in) begin
                bidir_r <= 1'b1;
            end
            thermal_oe_r <= !rst_now && temp_hot_in;
            oe_hist_r <= {oe_hist_r[OE_HIST_W-2:0], thermal_oe_r};
            link.dev_thermal_o <= 1'b0;
            link.dev_thermal_oe <= !rst_now && temp_hot_in;
            tcc_active_out <= !rst_now && tcc_enable_in &&
                (temp_hot_in || (bidir_r && ext_hot));
        end
    end

    assign bidir_on_out = bidir_r;

    // stop-grant acknowledge pending; the setting event wins
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            sg_pend_r <= 1'b0;
        end else if (ce_in) begin
            if (rst_now) begin
                sg_pend_r <= 1'b0;
            end else if (sg_set) begin
                sg_pend_r <= 1'b1;
            end else if (bus_r == BUS_DONE && rs_s == RS_IDLE_N) begin
                sg_pend_r <= 1'b0;
            end
        end
    end

    // request issue: drive command, lower strobe, wait for response
    always_ff @(posedge clk) begin
        if (!nrst_in) begin
            bus_r <= BUS_IDLE;
            link.req_o <= REQ_IDLE_N;
            link.req_oe <= 1'b0;
            link.stb_o <= 1'b1;
            link.stb_oe <= 1'b0;
            sg_ack_done_out <= 1'b0;
        end else if (ce_in) begin
            sg_ack_done_out <= 1'b0;
            if (rst_now) begin
                bus_r <= BUS_IDLE;
                link.req_o <= REQ_IDLE_N;
                link.req_oe <= 1'b0;
                link.stb_o <= 1'b1;
                link.stb_oe <= 1'b0;
            end else begin
                case (bus_r)
                    BUS_IDLE: begin
                        if (sg_pend_r) begin
                            bus_r <= BUS_CMD;
                            link.req_o <= REQ_STOP_GRANT_ACK_N;
                            link.req_oe <= 1'b1;
                        end
                    end
                    BUS_CMD: begin
                        bus_r <= BUS_STROBE;
                        link.stb_o <= 1'b0;
                        link.stb_oe <= 1'b1;
                    end
                    BUS_STROBE: begin
                        if (rs_s != RS_IDLE_N) begin
                            bus_r <= BUS_DONE;
                            link.req_o <= REQ_IDLE_N;
                            link.req_oe <= 1'b0;
                            link.stb_o <= 1'b1;
                            link.stb_oe <= 1'b0;
                        end
                    end
                    BUS_DONE: begin
                        if (rs_s == RS_IDLE_N) begin
                            bus_r <= BUS_IDLE;
                            sg_ack_done_out <= 1'b1;
                        end
                    end
                    default: bus_r <= BUS_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/ppr_link_checker.sv
// concurrent checks on the sideband link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ppr_link_checker (
    // link signals
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic supply_stable,
    input wire logic clock_stop_req_n,
    input wire logic sleep_req_n,
    input wire logic deep_sleep_req_n,
    input wire logic power_status_ind_n,
    input wire logic req_oe,
    input wire logic [ppr_pkg::REQ_W-1:0] req_n,
    input wire logic stb_oe,
    input wire logic addr_strobe0_n,
    input wire logic rs_oe,
    input wire logic [ppr_pkg::RS_W-1:0] response_status_n
);
    import ppr_pkg::*;
    default clocking @(posedge link_clk); endclocking
    default disable iff (!supply_stable);
    sequence s_awake; (reset_n && clock_stop_req_n && sleep_req_n)[*8];
    endsequence
    sequence s_deep; (reset_n && !sleep_req_n && !deep_sleep_req_n)[*8];
    endsequence
    property p_bus_rel; !reset_n |-> ##[1:2] (!req_oe && !stb_oe);
    endproperty
    property p_req_qual; !addr_strobe0_n |-> req_oe; endproperty
    property p_req_hold;
        !addr_strobe0_n && $past(!addr_strobe0_n) |-> $stable(req_n);
    endproperty
    property p_rs_start;
        $rose(rs_oe) |-> !addr_strobe0_n && response_status_n == RS_DONE_N;
    endproperty
    property p_rs_end;
        $fell(stb_oe) && reset_n |-> $past(response_status_n) == RS_DONE_N;
    endproperty
    property p_psi_rst; (!reset_n)[*3] |-> !power_status_ind_n; endproperty
    property p_psi_norm; s_awake ##1 s_awake |-> !power_status_ind_n;
    endproperty
    property p_psi_deep; s_deep ##1 s_deep |-> !power_status_ind_n;
    endproperty
    a_bus_rel: assert property (p_bus_rel) else $error("bus held");
    a_req_qual: assert property (p_req_qual) else $error("bad req");
    a_req_hold: assert property (p_req_hold) else $error("req moved");
    a_rs_start: assert property (p_rs_start) else $error("rs early");
    a_rs_end: assert property (p_rs_end) else $error("rs drop");
    a_psi_rst: assert property (p_psi_rst) else $error("psi rst");
    a_psi_norm: assert property (p_psi_norm) else $error("psi norm");
    a_psi_deep: assert property (p_psi_deep) else $error("psi deep");
endmodule
`default_nettype wire

// ### testbench/proc_power_reset_thermal_ctrl_tb_top.sv
// self-checking bench: platform end and device end joined by the link
`timescale 1ns/1ps
`default_nettype none
module proc_power_reset_thermal_ctrl_tb_top;
    import ppr_pkg::*;
    logic clk_in = 0, nrst_in = 0, dnrst = 0, sup = 0, rreq = 0, cs = 0;
    logic sl = 0, ds = 0, th = 0, hot = 0, thermal_control_circuit = 0, bid = 0, snp = 0;
    logic irq = 0, fill = 0, sg_seen = 0;
    logic [2:0] fidx = 3'h0;
    logic [3:0] strap = 4'h5;
    logic seen, psi, rv, run, cen, ben, pll, inr, tca, bon, sak, iak, sgd;
    logic [4:0] cmd;
    logic [4:0] last_cmd = 5'h00;
    logic [7:0] cval;
    logic [3:0] so;
    ppr_pwr_e pst;
    int n_fail = 0;
    int n_tests = 0;
    ppr_link_if lnk ();
    ppr_host_end #(.RESET_HOLD(50), .STRAP_SETUP(10)) i_ppr_host_end (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .link(lnk),
        .supply_ok_in(sup), .reset_req_in(rreq), .strap_in(strap),
        .clock_stop_in(cs), .sleep_in(sl), .deep_sleep_in(ds),
        .thermal_assert_in(th), .thermal_seen_out(seen),
        .power_status_out(psi), .req_valid_out(rv), .req_cmd_out(cmd),
        .cpu_running_out(run));
    ppr_dev_end i_ppr_dev_end (
        .link(lnk), .nrst_in(dnrst), .ce_in(1'b1), .temp_hot_in(hot),
        .tcc_enable_in(thermal_control_circuit), .bidir_enable_in(bid), .snoop_req_in(snp),
        .int_req_in(irq), .fill_in(fill), .fill_idx_in(fidx),
        .power_state_out(pst), .core_clk_en_out(cen), .bus_clk_en_out(ben),
        .pll_on_out(pll), .in_reset_out(inr), .tcc_active_out(tca),
        .bidir_on_out(bon), .snoop_ack_out(sak), .int_ack_out(iak),
        .sg_ack_done_out(sgd), .cache_valid_out(cval), .strap_out(so));
    ppr_link_checker i_ppr_link_checker (
        .link_clk(lnk.link_clk), .reset_n(lnk.reset_n),
        .supply_stable(lnk.supply_stable),
        .clock_stop_req_n(lnk.clock_stop_req_n),
        .sleep_req_n(lnk.sleep_req_n),
        .deep_sleep_req_n(lnk.deep_sleep_req_n),
        .power_status_ind_n(lnk.power_status_ind_n), .req_oe(lnk.req_oe),
        .req_n(lnk.req_n), .stb_oe(lnk.stb_oe),
        .addr_strobe0_n(lnk.addr_strobe0_n), .rs_oe(lnk.rs_oe),
        .response_status_n(lnk.response_status_n));
    initial forever #5 clk_in = ~clk_in;
    // capture single-cycle pulses for later comparison
    always @(posedge clk_in) if (rv) last_cmd <= cmd;
    always @(posedge lnk.link_clk) if (sgd) sg_seen <= 1'b1;
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic lk(input int n);
        repeat (n) @(posedge lnk.link_clk);
        #1;
    endtask
    task automatic t_power_up;
        int n = 0;
        sup = 1'b1;
        while (run !== 1'b1 && n < 500) begin
            @(posedge clk_in);
            n++;
        end
        chk("hold", 1, n >= 50);
        lk(12);
        chk("strap", 4'h5, so);
        chk("cache", 8'h00, cval);
        chk("state", PWR_NORMAL, pst);
        chk("psi", 1, psi);
    endtask
    task automatic t_thermal;
        thermal_control_circuit = 1'b1;
        hot = 1'b1;
        lk(12);
        chk("alert", 1, seen);
        chk("tcc hot", 1, tca);
        hot = 1'b0;
        th = 1'b1;
        lk(12);
        chk("in ignored", 0, tca);
        chk("bidir", 0, bon);
        bid = 1'b1;
        lk(12);
        chk("in engage", 1, tca);
        th = 1'b0;
        lk(12);
        chk("in release", 0, tca);
    endtask
    task automatic t_power_seq;
        fill = 1'b1;
        fidx = 3'h3;
        lk(1);
        fill = 1'b0;
        chk("fill", 8'h08, cval);
        snp = 1'b1;
        irq = 1'b1;
        cs = 1'b1;
        lk(30);
        chk("sg", PWR_STOP_GRANT, pst);
        chk("core off", 0, cen);
        chk("bus on", 1, ben);
        chk("snoop", 1, sak);
        chk("int", 1, iak);
        chk("ack cmd", 8'h08, last_cmd);
        chk("ack done", 1, sg_seen);
        sl = 1'b1;
        lk(12);
        chk("sleep", PWR_SLEEP, pst);
        chk("bus off", 0, ben);
        chk("pll", 1, pll);
        chk("no snoop", 0, sak);
        chk("no int", 0, iak);
        ds = 1'b1;
        lk(12);
        chk("deep", PWR_DEEP_SLEEP, pst);
        chk("psi deep", 1, psi);
        ds = 1'b0;
        lk(12);
        sl = 1'b0;
        lk(12);
        chk("back sg", PWR_STOP_GRANT, pst);
        chk("bus back", 1, ben);
    endtask
    task automatic t_warm_reset;
        rreq = 1'b1;
        lk(12);
        chk("state rst", PWR_NORMAL, pst);
        chk("in reset", 1, inr);
        chk("cache clr", 8'h00, cval);
        cs = 1'b0;
        snp = 1'b0;
        rreq = 1'b0;
        lk(30);
        chk("running", 1, run);
        chk("out reset", 0, inr);
    endtask
    task automatic report_and_stop;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        repeat (60) @(posedge clk_in);
        #1 dnrst = 1'b1;
        t_power_up;
        t_thermal;
        t_power_seq;
        t_warm_reset;
        report_and_stop;
    end
    initial begin
        #100000;
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire
